/* pkg/metering_irq_pkg.sv */
// Purpose: Shared constants for the metering interrupt flag block
// Assumes: 32-bit plain register port, word addresses in bytes
// Notes:   Offsets and bit positions used by the block and its bench
package metering_irq_pkg;

  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 32;

  // Register byte offsets
  localparam logic [7:0] ADDR_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_ENABLES = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;

  // Flag and enable bit positions, normal metering mode
  localparam int unsigned BIT_WAVEFORM = 0;
  localparam int unsigned BIT_PHASE_A  = 1;
  localparam int unsigned BIT_PHASE_B  = 2;
  localparam int unsigned BIT_PHASE_C  = 3;
  // Low-power completion bits
  localparam int unsigned BIT_LP_ONE   = 4;
  localparam int unsigned BIT_LP_TWO   = 5;
  localparam int unsigned FLAG_COUNT   = 6;

  localparam logic [5:0] FLAGS_RESET   = 6'h00;
  localparam logic [5:0] ENABLES_RESET = 6'h00;
  // Bits that belong to the normal metering mode
  localparam logic [5:0] NORMAL_MASK   = 6'h0F;
  localparam logic [5:0] LP_ONE_MASK   = 6'h10;
  localparam logic [5:0] LP_TWO_MASK   = 6'h20;

  // Operating mode codes in the mode register
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_LP_ONE  = 2'h1;
  localparam logic [1:0] MODE_LP_TWO  = 2'h2;
  localparam logic [1:0] MODE_RESET   = 2'h0;

endpackage : metering_irq_pkg

/* pkg/flag_if.sv */
// Purpose: Bundle between the register logic and the flag bank
// Assumes: Single clock domain
// Notes:   Carries events, write-one-to-clear mask and flag state
`timescale 1ns/10ps
interface flag_if;
  logic [5:0] events;
  logic [5:0] clear;
  logic [5:0] flags;

  modport ctrl (output events, output clear, input flags);
  modport bank (input events, input clear, output flags);
endinterface : flag_if

/* src/flag_bank.sv */
// Purpose: Sticky interrupt flags, set by events, cleared by writing one
// Assumes: Events are one-cycle pulses on the system clock
// Notes:   A set arriving with a clear wins
`timescale 1ns/10ps
module flag_bank
(
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  flag_if.bank      fl
);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      fl.flags <= metering_irq_pkg::FLAGS_RESET; // [R16]
    else
      fl.flags <= (fl.flags & ~fl.clear) | fl.events; // [R4] [R5] [R7] [R13] [R14]
  end

endmodule : flag_bank

/* src/metering_interrupt_flags.sv */
// Purpose: Interrupt flags, enables and active-low pin for a metering device
// Assumes: Event inputs are pulses from logic on the same clock
// Notes:   Registers: flags (W1C), enables, operating mode; read data one cycle later
`timescale 1ns/10ps
// Contract
// [R1] Phase B forward zero-crossing above threshold sets flag bit 2.
// [R2] Phase A forward zero-crossing above threshold sets flag bit 1.
// [R3] Set zero-crossing flag with enable one pulls interrupt pin low.
// [R4] Writing one clears phase B flag and withdraws its interrupt.
// [R5] Writing one clears phase A flag and withdraws its interrupt.
// [R6] Each 8 kHz waveform refresh sets flag bit 0.
// [R7] Writing one clears waveform flag; enabled interrupt withdrawn too.
// [R8] First low-power mode has one completion flag with own enable.
// [R9] Second low-power mode has one completion flag with own enable.
// [R10] Normal-mode sources have no effect in low-power modes.
// [R11] First low-power completion acts only in that mode.
// [R12] Second low-power completion acts only in that mode.
// [R13] Flags set regardless of enables; enables gate only the pin.
// [R14] Writing one clears phase C flag and withdraws its interrupt.
// [R15] Pin stays low while any enabled current-mode flag is set.
// [R16] After reset flags and enables are zero, pin high.
module metering_interrupt_flags
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        write_in,
  input  wire logic        read_in,
  input  wire logic        phase_a_zero_cross_in,
  input  wire logic        phase_b_zero_cross_in,
  input  wire logic        phase_c_zero_cross_in,
  input  wire logic        waveform_refresh_in,
  input  wire logic        low_power_one_done_in,
  input  wire logic        low_power_two_done_in,
  output logic [31:0]      rdata_out,
  output logic [1:0]       mode_out,
  output logic             interrupt_out_n
);

  logic [5:0] interrupt_enables;
  logic [1:0] mode;
  logic [5:0] mode_mask;
  logic [5:0] raw_events;
  logic [5:0] pending;
  logic       wr_flags;

  flag_if fl ();

  flag_bank u_flag_bank
  (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .fl         (fl)
  );

  function automatic logic [5:0] mask_for_mode(input logic [1:0] m);
    case (m)
      metering_irq_pkg::MODE_NORMAL: mask_for_mode = metering_irq_pkg::NORMAL_MASK;
      metering_irq_pkg::MODE_LP_ONE: mask_for_mode = metering_irq_pkg::LP_ONE_MASK;
      metering_irq_pkg::MODE_LP_TWO: mask_for_mode = metering_irq_pkg::LP_TWO_MASK;
      default:                       mask_for_mode = 6'h00;
    endcase
  endfunction : mask_for_mode

  always_comb
  begin
    raw_events = 6'h00;
    raw_events[metering_irq_pkg::BIT_WAVEFORM] = waveform_refresh_in; // [R6]
    raw_events[metering_irq_pkg::BIT_PHASE_A]  = phase_a_zero_cross_in; // [R2]
    raw_events[metering_irq_pkg::BIT_PHASE_B]  = phase_b_zero_cross_in; // [R1]
    raw_events[metering_irq_pkg::BIT_PHASE_C]  = phase_c_zero_cross_in;
    raw_events[metering_irq_pkg::BIT_LP_ONE]   = low_power_one_done_in; // [R8]
    raw_events[metering_irq_pkg::BIT_LP_TWO]   = low_power_two_done_in; // [R9]
  end

  assign mode_mask = mask_for_mode(mode);
  // Events of other modes are dropped
  assign fl.events = raw_events & mode_mask; // [R10] [R11] [R12] [R13]
  assign wr_flags  = write_in && (addr_in == metering_irq_pkg::ADDR_FLAGS);
  assign fl.clear  = wr_flags ? wdata_in[5:0] : 6'h00; // [R4] [R5] [R7] [R14]
  assign pending   = fl.flags & interrupt_enables & mode_mask; // [R3] [R15]

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      interrupt_enables <= metering_irq_pkg::ENABLES_RESET; // [R16]
    else if (write_in && addr_in == metering_irq_pkg::ADDR_ENABLES)
      interrupt_enables <= wdata_in[5:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      mode <= metering_irq_pkg::MODE_RESET;
    else if (write_in && addr_in == metering_irq_pkg::ADDR_MODE)
      mode <= wdata_in[1:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      mode_out <= metering_irq_pkg::MODE_RESET;
    else
      mode_out <= mode;
  end

  // Pin follows flag state one cycle later
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      interrupt_out_n <= 1'b1; // [R16]
    else
      interrupt_out_n <= ~(|pending); // [R3] [R15]
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      rdata_out <= 32'h0000_0000;
    else if (read_in)
    begin
      case (addr_in)
        metering_irq_pkg::ADDR_FLAGS:   rdata_out <= {26'h0, fl.flags}; // [R13]
        metering_irq_pkg::ADDR_ENABLES: rdata_out <= {26'h0, interrupt_enables};
        metering_irq_pkg::ADDR_MODE:    rdata_out <= {30'h0, mode};
        default:                        rdata_out <= 32'h0000_0000;
      endcase
    end
    else
      rdata_out <= 32'h0000_0000;
  end

  property p_zero_cross_b_sets;
    @(posedge clk_sys_in) disable iff (rst_in)
      (phase_b_zero_cross_in && mode == metering_irq_pkg::MODE_NORMAL)
      |=> fl.flags[metering_irq_pkg::BIT_PHASE_B];
  endproperty
  a_zero_cross_b_sets: assert property (p_zero_cross_b_sets) // [R1]
    else $error("phase B flag not set");

  property p_zero_cross_a_sets;
    @(posedge clk_sys_in) disable iff (rst_in)
      (phase_a_zero_cross_in && mode == metering_irq_pkg::MODE_NORMAL)
      |=> fl.flags[metering_irq_pkg::BIT_PHASE_A];
  endproperty
  a_zero_cross_a_sets: assert property (p_zero_cross_a_sets) // [R2]
    else $error("phase A flag not set");

  property p_pin_low;
    @(posedge clk_sys_in) disable iff (rst_in)
      (|pending) |=> !interrupt_out_n;
  endproperty
  a_pin_low: assert property (p_pin_low) // [R3]
    else $error("interrupt pin not low");

  sequence s_clear_b;
    wr_flags && wdata_in[metering_irq_pkg::BIT_PHASE_B]
      && !raw_events[metering_irq_pkg::BIT_PHASE_B];
  endsequence
  property p_clear_b;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_clear_b |=> !fl.flags[metering_irq_pkg::BIT_PHASE_B];
  endproperty
  a_clear_b: assert property (p_clear_b) // [R4]
    else $error("phase B flag not cleared");

  property p_clear_a;
    @(posedge clk_sys_in) disable iff (rst_in)
      (wr_flags && wdata_in[metering_irq_pkg::BIT_PHASE_A] && !phase_a_zero_cross_in)
      |=> !fl.flags[metering_irq_pkg::BIT_PHASE_A];
  endproperty
  a_clear_a: assert property (p_clear_a) // [R5]
    else $error("phase A flag not cleared");

  property p_waveform_sets;
    @(posedge clk_sys_in) disable iff (rst_in)
      (waveform_refresh_in && mode == metering_irq_pkg::MODE_NORMAL)
      |=> fl.flags[metering_irq_pkg::BIT_WAVEFORM];
  endproperty
  a_waveform_sets: assert property (p_waveform_sets) // [R6]
    else $error("waveform flag not set");

  property p_normal_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
      (mode != metering_irq_pkg::MODE_NORMAL && !(|(fl.flags & metering_irq_pkg::NORMAL_MASK)))
      |=> !(|(fl.flags & metering_irq_pkg::NORMAL_MASK));
  endproperty
  a_normal_quiet: assert property (p_normal_quiet) // [R10]
    else $error("normal flag set in low-power mode");

  property p_pin_high;
    @(posedge clk_sys_in) disable iff (rst_in)
      !(|pending) |=> interrupt_out_n;
  endproperty
  a_pin_high: assert property (p_pin_high) // [R15]
    else $error("interrupt pin low with nothing pending");

  property p_lp_one_only;
    @(posedge clk_sys_in) disable iff (rst_in)
      (mode != metering_irq_pkg::MODE_LP_ONE && !fl.flags[metering_irq_pkg::BIT_LP_ONE])
      |=> !fl.flags[metering_irq_pkg::BIT_LP_ONE];
  endproperty
  a_lp_one_only: assert property (p_lp_one_only) // [R11]
    else $error("low-power one flag set outside its mode");

  property p_lp_two_only;
    @(posedge clk_sys_in) disable iff (rst_in)
      (mode != metering_irq_pkg::MODE_LP_TWO && !fl.flags[metering_irq_pkg::BIT_LP_TWO])
      |=> !fl.flags[metering_irq_pkg::BIT_LP_TWO];
  endproperty
  a_lp_two_only: assert property (p_lp_two_only) // [R12]
    else $error("low-power two flag set outside its mode");

  property p_lp_one_sets;
    @(posedge clk_sys_in) disable iff (rst_in)
      (low_power_one_done_in && mode == metering_irq_pkg::MODE_LP_ONE)
      |=> fl.flags[metering_irq_pkg::BIT_LP_ONE];
  endproperty
  a_lp_one_sets: assert property (p_lp_one_sets) // [R8]
    else $error("low-power one flag not set");

  property p_lp_two_sets;
    @(posedge clk_sys_in) disable iff (rst_in)
      (low_power_two_done_in && mode == metering_irq_pkg::MODE_LP_TWO)
      |=> fl.flags[metering_irq_pkg::BIT_LP_TWO];
  endproperty
  a_lp_two_sets: assert property (p_lp_two_sets) // [R9]
    else $error("low-power two flag not set");

  property p_clear_c;
    @(posedge clk_sys_in) disable iff (rst_in)
      (wr_flags && wdata_in[metering_irq_pkg::BIT_PHASE_C] && !phase_c_zero_cross_in)
      |=> !fl.flags[metering_irq_pkg::BIT_PHASE_C];
  endproperty
  a_clear_c: assert property (p_clear_c) // [R14]
    else $error("phase C flag not cleared");

  property p_clear_waveform;
    @(posedge clk_sys_in) disable iff (rst_in)
      (wr_flags && wdata_in[metering_irq_pkg::BIT_WAVEFORM] && !waveform_refresh_in)
      |=> !fl.flags[metering_irq_pkg::BIT_WAVEFORM];
  endproperty
  a_clear_waveform: assert property (p_clear_waveform) // [R7]
    else $error("waveform flag not cleared");

  property p_set_regardless;
    @(posedge clk_sys_in) disable iff (rst_in)
      (|fl.events)
      |=> ((fl.flags & $past(fl.events)) == $past(fl.events));
  endproperty
  a_set_regardless: assert property (p_set_regardless) // [R13]
    else $error("event did not set its flag");

  property p_reset_state;
    @(posedge clk_sys_in)
      rst_in |=> (fl.flags == metering_irq_pkg::FLAGS_RESET) && interrupt_out_n
        && (interrupt_enables == metering_irq_pkg::ENABLES_RESET);
  endproperty
  a_reset_state: assert property (p_reset_state) // [R16]
    else $error("state not cleared by reset");

  // Enables and mode only move on a write, so the pin follows two edges later
  sequence s_event_enabled;
    (|(fl.events & interrupt_enables)) && !write_in;
  endsequence
  sequence s_pin_pulled;
    ##2 !interrupt_out_n;
  endsequence
  property p_event_to_pin;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_event_enabled |-> s_pin_pulled;
  endproperty
  a_event_to_pin: assert property (p_event_to_pin) // [R3]
    else $error("enabled event did not pull the pin low");

  sequence s_lp_one_enabled;
    low_power_one_done_in && mode == metering_irq_pkg::MODE_LP_ONE && !write_in
      && interrupt_enables[metering_irq_pkg::BIT_LP_ONE];
  endsequence
  property p_lp_one_to_pin;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_lp_one_enabled |-> s_pin_pulled;
  endproperty
  a_lp_one_to_pin: assert property (p_lp_one_to_pin) // [R8] [R11]
    else $error("low-power one completion did not pull the pin low");

  sequence s_lp_two_enabled;
    low_power_two_done_in && mode == metering_irq_pkg::MODE_LP_TWO && !write_in
      && interrupt_enables[metering_irq_pkg::BIT_LP_TWO];
  endsequence
  property p_lp_two_to_pin;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_lp_two_enabled |-> s_pin_pulled;
  endproperty
  a_lp_two_to_pin: assert property (p_lp_two_to_pin) // [R9] [R12]
    else $error("low-power two completion did not pull the pin low");

  sequence s_withdraw;
    wr_flags && ((pending & ~wdata_in[5:0]) == 6'h00)
      && ((fl.events & interrupt_enables & mode_mask) == 6'h00);
  endsequence
  sequence s_pin_released;
    ##2 interrupt_out_n;
  endsequence
  property p_withdraw;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_withdraw |-> s_pin_released;
  endproperty
  a_withdraw: assert property (p_withdraw) // [R4] [R5] [R7] [R14]
    else $error("pin not released after clearing");

  property p_lp_one_pin_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
      (mode == metering_irq_pkg::MODE_LP_ONE
        && !(fl.flags[metering_irq_pkg::BIT_LP_ONE]
        && interrupt_enables[metering_irq_pkg::BIT_LP_ONE]))
      |=> interrupt_out_n;
  endproperty
  a_lp_one_pin_quiet: assert property (p_lp_one_pin_quiet) // [R10] [R11]
    else $error("pin low in low-power one without its flag");

  property p_lp_two_pin_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
      (mode == metering_irq_pkg::MODE_LP_TWO
        && !(fl.flags[metering_irq_pkg::BIT_LP_TWO]
        && interrupt_enables[metering_irq_pkg::BIT_LP_TWO]))
      |=> interrupt_out_n;
  endproperty
  a_lp_two_pin_quiet: assert property (p_lp_two_pin_quiet) // [R10] [R12]
    else $error("pin low in low-power two without its flag");

  property p_flags_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!(|fl.events) && !wr_flags)
      |=> $stable(fl.flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // [R13]
    else $error("flag changed without event or clear");

  property p_rdata_flags;
    @(posedge clk_sys_in) disable iff (rst_in)
      (read_in && addr_in == metering_irq_pkg::ADDR_FLAGS)
      |=> (rdata_out == {26'h0, $past(fl.flags)});
  endproperty
  a_rdata_flags: assert property (p_rdata_flags) // [R13]
    else $error("flag read does not show flag state");

  property p_enables_gate;
    @(posedge clk_sys_in) disable iff (rst_in)
      (write_in && addr_in == metering_irq_pkg::ADDR_ENABLES && wdata_in[5:0] == 6'h00)
      |-> s_pin_released;
  endproperty
  a_enables_gate: assert property (p_enables_gate) // [R13]
    else $error("pin low with all enables off");

endmodule : metering_interrupt_flags

/* dv/host_irq_model.sv */
// Purpose: Host side that watches the active-low interrupt pin
// Assumes: Host samples the pin on the system clock
// Notes:   Counts interrupt requests as high-to-low changes of the pin
`timescale 1ns/10ps
module host_irq_model
(
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic interrupt_out_n,
  output int        irq_count_out
);
  logic pin_last;

  always_ff @(posedge clk_sys_in)
  begin
    pin_last <= interrupt_out_n;
    if (rst_in)
      irq_count_out <= 0;
    else if (pin_last && !interrupt_out_n)
      irq_count_out <= irq_count_out + 1;
  end
endmodule : host_irq_model

/* dv/test_metering_interrupt_flags.sv */
// Purpose: Self-checking bench for the metering interrupt flag block
// Assumes: Register read data stand one cycle after the read strobe
// Notes:   Events are single-cycle pulses, bit order as the flag register
`timescale 1ns/10ps
module test_metering_interrupt_flags;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic [7:0]  addr_in    = 8'h00;
  logic [31:0] wdata_in   = 32'h0000_0000;
  logic        write_in   = 1'b0;
  logic        read_in    = 1'b0;
  logic [5:0]  ev         = 6'h00;
  logic [31:0] rdata_out;
  logic [1:0]  mode_out;
  logic        interrupt_out_n;
  int          irq_seen;
  int          err_count  = 0;
  int          checks     = 0;
  int          b;

  always #10 clk_sys_in = ~clk_sys_in;

  metering_interrupt_flags i_dut
  (
    .clk_sys_in (clk_sys_in), .rst_in (rst_in), .addr_in (addr_in),
    .wdata_in (wdata_in), .write_in (write_in), .read_in (read_in),
    .waveform_refresh_in (ev[0]), .phase_a_zero_cross_in (ev[1]),
    .phase_b_zero_cross_in (ev[2]), .phase_c_zero_cross_in (ev[3]),
    .low_power_one_done_in (ev[4]), .low_power_two_done_in (ev[5]),
    .rdata_out (rdata_out), .mode_out (mode_out), .interrupt_out_n (interrupt_out_n)
  );

  host_irq_model i_host
  (
    .clk_sys_in (clk_sys_in), .rst_in (rst_in),
    .interrupt_out_n (interrupt_out_n), .irq_count_out (irq_seen)
  );

  task automatic close_out;
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t: word %h, expected %h", $time, got, exp);
      err_count++;
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t: pin %b, expected %b", $time, got, exp);
      err_count++;
    end
  endtask : cmp1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clk_sys_in);
    write_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clk_sys_in);
    read_in <= 1'b0;
    #1 cmp32(rdata_out, exp);
  endtask : rd

  task automatic pulse(input int i);
    @(posedge clk_sys_in);
    ev <= 6'h01 << i;
    @(posedge clk_sys_in);
    ev <= 6'h00;
  endtask : pulse

  // Pin settles two edges after the event or write is taken
  task automatic pin(input logic exp);
    repeat (2) @(posedge clk_sys_in);
    #1 cmp1(interrupt_out_n, exp);
  endtask : pin

  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
    rd(metering_irq_pkg::ADDR_ENABLES, 32'h0000_0000);
    cmp1(interrupt_out_n, 1'b1);
    rd(8'h0C, 32'h0000_0000);
    for (b = 0; b < 4; b++)
    begin
      pulse(b);
      pin(1'b1);
      rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0001 << b);
      wr(metering_irq_pkg::ADDR_ENABLES, 32'h0000_0001 << b);
      pin(1'b0);
      wr(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0001 << b);
      pin(1'b1);
      rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
    end
    wr(metering_irq_pkg::ADDR_ENABLES, 32'h0000_003F);
    pulse(1);
    pulse(2);
    wr(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0002);
    pin(1'b0);
    wr(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0004);
    pin(1'b1);
    pulse(1);
    wr(metering_irq_pkg::ADDR_MODE, 32'h0000_0001);
    pin(1'b1);
    wr(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0002);
    for (b = 4; b < 6; b++)
    begin
      wr(metering_irq_pkg::ADDR_MODE, 32'(b - 3));
      for (int i = 0; i < 4; i++)
        pulse(i);
      pulse(9 - b);
      pin(1'b1);
      cmp32(32'(mode_out), 32'(b - 3));
      rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
      pulse(b);
      pin(1'b0);
      rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0001 << b);
      wr(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0001 << b);
      pin(1'b1);
    end
    pulse(5);
    pin(1'b0);
    cmp32(32'(irq_seen), 32'h0000_0009);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1 cmp1(interrupt_out_n, 1'b1);
    rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
    rd(metering_irq_pkg::ADDR_ENABLES, 32'h0000_0000);
    rd(metering_irq_pkg::ADDR_MODE, 32'h0000_0000);
    wr(metering_irq_pkg::ADDR_ENABLES, 32'h0000_003F);
    wr(metering_irq_pkg::ADDR_MODE, 32'h0000_0003);
    for (b = 0; b < 6; b++)
      pulse(b);
    pin(1'b1);
    rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
    wr(metering_irq_pkg::ADDR_MODE, 32'h0000_0000);
    pulse(2);
    pin(1'b0);
    wr(metering_irq_pkg::ADDR_ENABLES, 32'h0000_0000);
    pin(1'b1);
    rd(metering_irq_pkg::ADDR_FLAGS, 32'h0000_0004);
    close_out();
  end
endmodule : test_metering_interrupt_flags
